/* hw/ssr_pkg.sv */
package ssr_pkg;
  localparam int unsigned SB_QUES_BIT  = 3;
  localparam int unsigned SB_MAV_BIT   = 4;
  localparam int unsigned SB_ESB_BIT   = 5;
  localparam int unsigned SB_RQS_BIT   = 6;
  localparam int unsigned SB_OPER_BIT  = 7;
  localparam int unsigned SB_EAV_BIT   = 2;
  localparam logic [7:0]  SRQ_SRC_MASK = 8'hbc;
  localparam int unsigned EV_OPC_BIT   = 0;
  localparam int unsigned EV_PON_BIT   = 7;
  localparam logic [15:0] FILT_ALL_ONE = 16'hffff;
  localparam logic [15:0] REG_ZERO     = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [7:0]  BYTE_ONES    = 8'hff;
  localparam logic [3:0]  QSEL_STB     = 4'h0;
  localparam logic [3:0]  QSEL_ESR     = 4'h1;
  localparam logic [3:0]  QSEL_ESE     = 4'h2;
  localparam logic [3:0]  QSEL_SRE     = 4'h3;
  localparam logic [3:0]  QSEL_PPE     = 4'h4;
  localparam logic [3:0]  QSEL_IST     = 4'h5;
  localparam logic [3:0]  QSEL_OCOND   = 4'h6;
  localparam logic [3:0]  QSEL_OEVT    = 4'h7;
  localparam logic [3:0]  QSEL_OEN     = 4'h8;
  localparam logic [3:0]  QSEL_OPTR    = 4'h9;
  localparam logic [3:0]  QSEL_ONTR    = 4'ha;
  localparam logic [3:0]  QSEL_QCOND   = 4'hb;
  localparam logic [3:0]  QSEL_QEVT    = 4'hc;
  localparam logic [3:0]  QSEL_QEN     = 4'hd;
  localparam logic [3:0]  QSEL_QPTR    = 4'he;
  localparam logic [3:0]  QSEL_QNTR    = 4'hf;
  localparam logic [15:0] NO_ERROR_CODE = 16'h0000;
endpackage : ssr_pkg

/* hw/ssr_err_queue.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_err_queue
  import ssr_pkg::*;
#(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        clear_i,
  input  wire logic        push_i,
  input  wire logic [15:0] push_code_i,
  input  wire logic        pop_i,
  output logic [15:0]      pop_code_o,
  output logic             not_empty_o
);
  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0]   cnt;
    logic [15:0]   code;
  } ssr_eq_state_t;

  ssr_eq_state_t st_r;
  ssr_eq_state_t st_nxt;
  logic [15:0]   mem_r [DEPTH];
  logic          do_push;
  logic          do_pop;

  // A full queue drops new errors rather than losing the oldest cause.
  assign do_pop  = pop_i && (st_r.cnt != '0);
  assign do_push = push_i && (st_r.cnt < (AW+1)'(DEPTH) || do_pop);

  always_comb begin
    st_nxt = st_r;
    if (pop_i) begin
      st_nxt.code = do_pop ? mem_r[st_r.rd] : NO_ERROR_CODE;
    end
    if (do_pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    if (do_push) begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    // An error reported in the clearing cycle survives as the first entry.
    if (clear_i) begin
      st_nxt.rd  = '0;
      st_nxt.wr  = AW'(push_i);
      st_nxt.cnt = (AW+1)'(push_i);
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && clear_i && push_i) begin
      mem_r[0] <= push_code_i;
    end else if (clk_en_i && do_push) begin
      mem_r[st_r.wr] <= push_code_i;
    end
  end

  assign pop_code_o  = st_r.code;
  assign not_empty_o = (st_r.cnt != '0);

  a_pop_empty_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && pop_i && st_r.cnt == '0 |=> pop_code_o == NO_ERROR_CODE)
    else $error("empty queue pop did not return zero");
  a_pop_count_step: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && pop_i && !push_i && !clear_i && st_r.cnt != '0 |=> st_r.cnt == $past(st_r.cnt) - 1'b1)
    else $error("pop did not remove exactly one entry");
endmodule : ssr_err_queue
`default_nettype wire

/* hw/ssr_status_core.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_status_core
  import ssr_pkg::*;
#(
  parameter int unsigned EQ_DEPTH = 8,
  parameter int unsigned EQ_AW    = 3
) (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        pon_clear_flag_i,
  input  wire logic        cmd_cls_i,
  input  wire logic        cmd_status_preset_i,
  input  wire logic        cmd_dev_clear_i,
  input  wire logic        cmd_line_start_i,
  input  wire logic        cmd_settings_reset_i,
  input  wire logic        cmd_opc_i,
  input  wire logic        ops_idle_i,
  input  wire logic        wr_sre_i,
  input  wire logic        wr_ese_i,
  input  wire logic        wr_ppe_i,
  input  wire logic [7:0]  wr_byte_i,
  input  wire logic        wr_oper_en_i,
  input  wire logic        wr_oper_ptr_i,
  input  wire logic        wr_oper_ntr_i,
  input  wire logic        wr_ques_en_i,
  input  wire logic        wr_ques_ptr_i,
  input  wire logic        wr_ques_ntr_i,
  input  wire logic [15:0] wr_word_i,
  input  wire logic        pp_config_i,
  input  wire logic [2:0]  pp_line_i,
  input  wire logic        pp_sense_i,
  input  wire logic        pp_unconfig_i,
  input  wire logic        pp_active_i,
  input  wire logic [15:0] oper_cond_i,
  input  wire logic [15:0] ques_cond_i,
  input  wire logic [5:2]  event_err_i,
  input  wire logic [15:0] err_code_i,
  input  wire logic        mav_i,
  input  wire logic        query_i,
  input  wire logic [3:0]  query_sel_i,
  input  wire logic        err_query_i,
  output logic [15:0]      query_data_o,
  output logic [15:0]      err_code_o,
  output logic [7:0]       status_byte_o,
  output logic             srq_o,
  output logic [7:0]       pp_data_o,
  output logic [7:0]       pp_data_oe_o,
  output logic             ist_o,
  output logic             clear_out_buf_o,
  output logic             clear_in_proc_o,
  output logic             settings_reset_o
);
  typedef struct packed {
    logic [7:0]  request_enable_mask;
    logic [7:0]  event_enable_mask;
    logic [7:0]  standard_event_register;
    logic [7:0]  poll_enable_mask;
    logic [15:0] oper_evt;
    logic [15:0] oper_en;
    logic [15:0] oper_ptr;
    logic [15:0] oper_ntr;
    logic [15:0] oper_prev;
    logic [15:0] ques_evt;
    logic [15:0] ques_en;
    logic [15:0] ques_ptr;
    logic [15:0] ques_ntr;
    logic [15:0] ques_prev;
    logic        opc_wait;
    logic        pp_cfg;
    logic [2:0]  pp_line;
    logic        pp_sense;
    logic        pon_done;
    logic [15:0] qdata;
    logic        clr_out;
    logic        clr_in;
    logic        set_rst;
  } ssr_state_t;

  ssr_state_t st_r;
  ssr_state_t st_nxt;
  logic [7:0] stb;
  logic       srq_req;
  logic       ist;
  logic       eq_avail;
  logic       pon;
  logic       eq_clear;
  logic [15:0] oper_edge;
  logic [15:0] ques_edge;

  // Power-on is the first enabled cycle after reset; the clear flag is sampled then.
  assign pon      = !st_r.pon_done;
  assign eq_clear = pon || cmd_cls_i;

  // A falling filter bit catches the 1-to-0 change of its condition bit.
  assign oper_edge = (oper_cond_i & ~st_r.oper_prev & st_r.oper_ptr)
                   | (~oper_cond_i & st_r.oper_prev & st_r.oper_ntr);
  assign ques_edge = (ques_cond_i & ~st_r.ques_prev & st_r.ques_ptr)
                   | (~ques_cond_i & st_r.ques_prev & st_r.ques_ntr);

  ssr_err_queue #(
    .DEPTH (EQ_DEPTH),
    .AW    (EQ_AW)
  ) u_err_queue (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .clear_i     (eq_clear),
    .push_i      (|event_err_i),
    .push_code_i (err_code_i),
    .pop_i       (err_query_i),
    .pop_code_o  (err_code_o),
    .not_empty_o (eq_avail)
  );

  always_comb begin
    stb              = BYTE_ZERO;
    stb[SB_EAV_BIT]  = eq_avail;
    stb[SB_QUES_BIT] = |(st_r.ques_evt & st_r.ques_en);
    stb[SB_MAV_BIT]  = mav_i;
    stb[SB_ESB_BIT]  = |(st_r.standard_event_register & st_r.event_enable_mask);
    stb[SB_OPER_BIT] = |(st_r.oper_evt & st_r.oper_en);
    // Released as soon as the enabled causes go away, no separate latch.
    srq_req          = |(stb & st_r.request_enable_mask & SRQ_SRC_MASK);
    stb[SB_RQS_BIT]  = srq_req;
    ist              = |(st_r.poll_enable_mask & stb);
  end

  always_comb begin
    st_nxt         = st_r;
    st_nxt.clr_out = 1'b0;
    st_nxt.clr_in  = 1'b0;
    st_nxt.set_rst = cmd_settings_reset_i;
    st_nxt.pon_done = 1'b1;
    // Transition filters: rising via ptr, falling via ntr.
    st_nxt.oper_evt  = st_r.oper_evt | oper_edge;
    st_nxt.ques_evt  = st_r.ques_evt | ques_edge;
    st_nxt.oper_prev = oper_cond_i;
    st_nxt.ques_prev = ques_cond_i;
    if (cmd_opc_i) begin
      st_nxt.opc_wait = 1'b1;
    end
    if (wr_sre_i) st_nxt.request_enable_mask = wr_byte_i;
    if (wr_ese_i) st_nxt.event_enable_mask = wr_byte_i;
    if (wr_ppe_i) st_nxt.poll_enable_mask = wr_byte_i;
    if (wr_oper_en_i) st_nxt.oper_en = wr_word_i;
    if (wr_oper_ptr_i) st_nxt.oper_ptr = wr_word_i;
    if (wr_oper_ntr_i) st_nxt.oper_ntr = wr_word_i;
    if (wr_ques_en_i) st_nxt.ques_en = wr_word_i;
    if (wr_ques_ptr_i) st_nxt.ques_ptr = wr_word_i;
    if (wr_ques_ntr_i) st_nxt.ques_ntr = wr_word_i;
    if (pp_config_i) begin
      st_nxt.pp_cfg   = 1'b1;
      st_nxt.pp_line  = pp_line_i;
      st_nxt.pp_sense = pp_sense_i;
    end else if (pp_unconfig_i) begin
      st_nxt.pp_cfg = 1'b0;
    end
    if (cmd_cls_i) begin
      st_nxt.standard_event_register      = BYTE_ZERO;
      // An edge in the clearing cycle is a new event and is kept.
      st_nxt.oper_evt = oper_edge;
      st_nxt.ques_evt = ques_edge;
      st_nxt.opc_wait = 1'b0;
    end
    // Event sources are merged after clear-status so a same-cycle event is kept.
    st_nxt.standard_event_register[5:2] = st_nxt.standard_event_register[5:2] | event_err_i;
    if (st_r.opc_wait && ops_idle_i) begin
      st_nxt.standard_event_register[EV_OPC_BIT] = 1'b1;
      st_nxt.opc_wait        = 1'b0;
    end
    if (cmd_status_preset_i || (pon && pon_clear_flag_i)) begin
      st_nxt.oper_en  = REG_ZERO;
      st_nxt.ques_en  = REG_ZERO;
      st_nxt.oper_ptr = FILT_ALL_ONE;
      st_nxt.ques_ptr = FILT_ALL_ONE;
      st_nxt.oper_ntr = REG_ZERO;
      st_nxt.ques_ntr = REG_ZERO;
    end
    if (pon) begin
      st_nxt.clr_out = 1'b1;
      st_nxt.clr_in  = 1'b1;
      st_nxt.standard_event_register[EV_PON_BIT] = 1'b1;
      if (pon_clear_flag_i) begin
        st_nxt.request_enable_mask      = BYTE_ZERO;
        st_nxt.event_enable_mask      = BYTE_ZERO;
        st_nxt.poll_enable_mask      = BYTE_ZERO;
        st_nxt.oper_evt = REG_ZERO;
        st_nxt.ques_evt = REG_ZERO;
        st_nxt.standard_event_register      = BYTE_ZERO;
        st_nxt.standard_event_register[EV_PON_BIT] = 1'b1;
      end
    end
    if (cmd_dev_clear_i) begin
      st_nxt.clr_out  = 1'b1;
      st_nxt.clr_in   = 1'b1;
      st_nxt.opc_wait = 1'b0;
    end
    if (cmd_line_start_i) begin
      st_nxt.clr_out = 1'b1;
    end
    if (query_i) begin
      if (query_sel_i == QSEL_STB) st_nxt.qdata = {8'h00, stb};
      else if (query_sel_i == QSEL_ESR) st_nxt.qdata = {8'h00, st_r.standard_event_register};
      else if (query_sel_i == QSEL_ESE) st_nxt.qdata = {8'h00, st_r.event_enable_mask};
      else if (query_sel_i == QSEL_SRE) st_nxt.qdata = {8'h00, st_r.request_enable_mask};
      else if (query_sel_i == QSEL_PPE) st_nxt.qdata = {8'h00, st_r.poll_enable_mask};
      else if (query_sel_i == QSEL_IST) st_nxt.qdata = {15'h0000, ist};
      else if (query_sel_i == QSEL_OCOND) st_nxt.qdata = oper_cond_i;
      else if (query_sel_i == QSEL_OEVT) st_nxt.qdata = st_r.oper_evt;
      else if (query_sel_i == QSEL_OEN) st_nxt.qdata = st_r.oper_en;
      else if (query_sel_i == QSEL_OPTR) st_nxt.qdata = st_r.oper_ptr;
      else if (query_sel_i == QSEL_ONTR) st_nxt.qdata = st_r.oper_ntr;
      else if (query_sel_i == QSEL_QCOND) st_nxt.qdata = ques_cond_i;
      else if (query_sel_i == QSEL_QEVT) st_nxt.qdata = st_r.ques_evt;
      else if (query_sel_i == QSEL_QEN) st_nxt.qdata = st_r.ques_en;
      else if (query_sel_i == QSEL_QPTR) st_nxt.qdata = st_r.ques_ptr;
      else st_nxt.qdata = st_r.ques_ntr;
      // Reading an event part clears it, but a new edge in the same cycle survives.
      if (query_sel_i == QSEL_ESR) st_nxt.standard_event_register = st_nxt.standard_event_register & ~st_r.standard_event_register | ({4'h0, event_err_i} << 2)
        | {7'h00, st_r.opc_wait && ops_idle_i};
      if (query_sel_i == QSEL_OEVT) st_nxt.oper_evt = oper_edge;
      if (query_sel_i == QSEL_QEVT) st_nxt.ques_evt = ques_edge;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  // The status byte has no reset bit; its sources are cleared instead.
  assign status_byte_o    = stb;
  assign srq_o            = srq_req;
  assign ist_o            = ist;
  assign query_data_o     = st_r.qdata;
  assign clear_out_buf_o  = st_r.clr_out;
  assign clear_in_proc_o  = st_r.clr_in;
  assign settings_reset_o = st_r.set_rst;

  // Only the allocated line is driven, so other devices can answer on theirs.
  always_comb begin
    pp_data_o    = BYTE_ZERO;
    pp_data_oe_o = BYTE_ZERO;
    if (pp_active_i && st_r.pp_cfg) begin
      pp_data_oe_o[st_r.pp_line] = 1'b1;
      pp_data_o[st_r.pp_line]    = ist ^ st_r.pp_sense;
    end
  end

  a_srq_cause: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    srq_o == ((status_byte_o[SB_EAV_BIT] && st_r.request_enable_mask[SB_EAV_BIT])
      || (status_byte_o[SB_QUES_BIT] && st_r.request_enable_mask[SB_QUES_BIT]) || (status_byte_o[SB_MAV_BIT] && st_r.request_enable_mask[SB_MAV_BIT])
      || (status_byte_o[SB_ESB_BIT] && st_r.request_enable_mask[SB_ESB_BIT]) || (status_byte_o[SB_OPER_BIT] && st_r.request_enable_mask[SB_OPER_BIT])))
    else $error("service request does not match enabled status");
  a_opc_sets_esb: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && st_r.pon_done && st_r.opc_wait && ops_idle_i && !query_i && !wr_ese_i && st_r.event_enable_mask[EV_OPC_BIT]
    |=> status_byte_o[SB_ESB_BIT])
    else $error("completion did not raise event summary");
  a_ntr_latch: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && st_r.pon_done && !cmd_cls_i && !query_i && !cmd_status_preset_i
    && |(~oper_cond_i & st_r.oper_prev & st_r.oper_ntr)
    |=> |st_r.oper_evt)
    else $error("falling edge not latched");
  a_pp_one_line: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $countones(pp_data_oe_o) == ((pp_active_i && st_r.pp_cfg) ? 1 : 0))
    else $error("parallel poll drives more than one line");
  a_cls_clears: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && st_r.pon_done && cmd_cls_i && event_err_i == 4'h0 && !(st_r.opc_wait && ops_idle_i)
    && !wr_sre_i && !wr_ese_i
    |=> st_r.standard_event_register == BYTE_ZERO && st_r.request_enable_mask == $past(st_r.request_enable_mask) && st_r.event_enable_mask == $past(st_r.event_enable_mask))
    else $error("clear status misbehaved");
  a_preset_filters: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && cmd_status_preset_i |=> st_r.oper_ptr == FILT_ALL_ONE && st_r.oper_ntr == REG_ZERO)
    else $error("preset did not set filters");
  a_dcl_keeps: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && st_r.pon_done && cmd_dev_clear_i && !wr_sre_i |=> clear_out_buf_o && clear_in_proc_o
    && st_r.request_enable_mask == $past(st_r.request_enable_mask))
    else $error("device clear wrong");
  a_line_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    clk_en_i && cmd_line_start_i |=> clear_out_buf_o)
    else $error("line start did not clear output buffer");
endmodule : ssr_status_core
`default_nettype wire

/* bench/ssr_bus_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ssr_bus_ctrl_model (
  input  wire logic       core_clk_i,
  input  wire logic [7:0] pp_data_i,
  input  wire logic [7:0] pp_data_oe_i,
  input  wire logic       srq_i,
  input  wire logic [7:0] status_byte_i,
  output logic      [7:0] dio_o,
  output logic      [7:0] poll_byte_o
);
  // A released data line floats to the pull-up level, so a stale value can never pass for an answer.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dio_o[i] = pp_data_oe_i[i] ? pp_data_i[i] : 1'h1;
    end
  end
  // The controller answers a pending service request with a serial poll on the next edge.
  always_ff @(posedge core_clk_i) begin
    if (srq_i) begin
      poll_byte_o <= status_byte_i;
    end
  end
endmodule : ssr_bus_ctrl_model
`default_nettype wire

/* bench/test_status_service_request_logic.sv */
`timescale 1ns/1ps
`default_nettype none
module test_status_service_request_logic;
  import ssr_pkg::*;
  typedef struct {int k; logic [15:0] d; logic [3:0] sel; logic [15:0] exp;} ssr_row_t;
  logic core_clk_i = 1'h0, sys_rst_i = 1'h1, clk_en_i = 1'h1, pon_clear_flag_i = 1'h1, ops_idle_i = 1'h1;
  logic cmd_cls_i = 1'h0, cmd_status_preset_i = 1'h0, cmd_dev_clear_i = 1'h0, cmd_line_start_i = 1'h0;
  logic cmd_settings_reset_i = 1'h0, cmd_opc_i = 1'h0, wr_sre_i = 1'h0, wr_ese_i = 1'h0, wr_ppe_i = 1'h0;
  logic wr_oper_en_i = 1'h0, wr_oper_ptr_i = 1'h0, wr_oper_ntr_i = 1'h0, wr_ques_en_i = 1'h0;
  logic wr_ques_ptr_i = 1'h0, wr_ques_ntr_i = 1'h0, pp_config_i = 1'h0, pp_sense_i = 1'h0;
  logic pp_unconfig_i = 1'h0, pp_active_i = 1'h0, mav_i = 1'h0, query_i = 1'h0, err_query_i = 1'h0;
  logic [7:0]  wr_byte_i = 8'h00;
  logic [2:0]  pp_line_i = 3'h0;
  logic [3:0]  query_sel_i = 4'h0;
  logic [5:2]  event_err_i = 4'h0;
  logic [15:0] wr_word_i = 16'h0000, oper_cond_i = 16'h0000, ques_cond_i = 16'h0000, err_code_i = 16'h0000;
  logic [15:0] query_data_o, err_code_o;
  logic [7:0]  status_byte_o, pp_data_o, pp_data_oe_o, dio, poll_byte;
  logic        srq_o, ist_o, clear_out_buf_o, clear_in_proc_o, settings_reset_o;
  int          n_errors = 0;
  int          n_tests = 0;
  ssr_row_t    rows [23];

  ssr_status_core dut_u (
    .core_clk_i, .sys_rst_i, .clk_en_i, .pon_clear_flag_i, .cmd_cls_i, .cmd_status_preset_i,
    .cmd_dev_clear_i, .cmd_line_start_i, .cmd_settings_reset_i, .cmd_opc_i, .ops_idle_i,
    .wr_sre_i, .wr_ese_i, .wr_ppe_i, .wr_byte_i, .wr_oper_en_i, .wr_oper_ptr_i, .wr_oper_ntr_i,
    .wr_ques_en_i, .wr_ques_ptr_i, .wr_ques_ntr_i, .wr_word_i, .pp_config_i, .pp_line_i, .pp_sense_i,
    .pp_unconfig_i, .pp_active_i, .oper_cond_i, .ques_cond_i, .event_err_i, .err_code_i, .mav_i,
    .query_i, .query_sel_i, .err_query_i, .query_data_o, .err_code_o, .status_byte_o, .srq_o,
    .pp_data_o, .pp_data_oe_o, .ist_o, .clear_out_buf_o, .clear_in_proc_o, .settings_reset_o
  );
  ssr_bus_ctrl_model ctrl_u (
    .core_clk_i, .pp_data_i(pp_data_o), .pp_data_oe_i(pp_data_oe_o), .srq_i(srq_o),
    .status_byte_i(status_byte_o), .dio_o(dio), .poll_byte_o(poll_byte)
  );

  always #20 core_clk_i = ~core_clk_i;

  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc
  // Callers must not pulse the same strobe twice in a row without a cycle between.
  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pulse
  task automatic q(input logic [3:0] sel, input logic [15:0] exp);
    query_sel_i = sel;
    pulse(query_i);
    chk(query_data_o, exp);
    cyc(1);
  endtask : q
  task automatic wr(input int k, input logic [15:0] d);
    wr_word_i = d;
    wr_byte_i = d[7:0];
    {wr_sre_i, wr_ese_i, wr_ppe_i, wr_oper_en_i, wr_oper_ptr_i, wr_oper_ntr_i, wr_ques_en_i,
     wr_ques_ptr_i, wr_ques_ntr_i} = (k == 0) ? 9'h000 : 9'h100 >> (k - 1);
    cyc(1);
    {wr_sre_i, wr_ese_i, wr_ppe_i, wr_oper_en_i, wr_oper_ptr_i, wr_oper_ntr_i, wr_ques_en_i,
     wr_ques_ptr_i, wr_ques_ntr_i} = 9'h000;
    cyc(1);
  endtask : wr
  task automatic wait_srq(input logic exp);
    for (int i = 0; i < 8 && srq_o !== exp; i++) cyc(1);
  endtask : wait_srq

  initial begin
    rows = '{'{0, 0, QSEL_ESR, 16'h0080}, '{0, 0, QSEL_ESR, 16'h0000}, '{0, 0, QSEL_STB, 16'h0000},
             '{0, 0, QSEL_OPTR, 16'hffff}, '{0, 0, QSEL_ONTR, 16'h0000}, '{0, 0, QSEL_QPTR, 16'hffff},
             '{0, 0, QSEL_QNTR, 16'h0000}, '{0, 0, QSEL_OEN, 16'h0000}, '{0, 0, QSEL_QEN, 16'h0000},
             '{0, 0, QSEL_ESE, 16'h0000}, '{0, 0, QSEL_SRE, 16'h0000}, '{0, 0, QSEL_PPE, 16'h0000},
             '{0, 0, QSEL_OCOND, 16'h0000}, '{0, 0, QSEL_QCOND, 16'h0000},
             '{1, 16'h00a5, QSEL_SRE, 16'h00a5}, '{2, 16'h005a, QSEL_ESE, 16'h005a},
             '{3, 16'h00c3, QSEL_PPE, 16'h00c3}, '{4, 16'h1234, QSEL_OEN, 16'h1234},
             '{5, 16'h0f0f, QSEL_OPTR, 16'h0f0f}, '{6, 16'h0010, QSEL_ONTR, 16'h0010},
             '{7, 16'h4321, QSEL_QEN, 16'h4321}, '{8, 16'h00ff, QSEL_QPTR, 16'h00ff},
             '{9, 16'hff00, QSEL_QNTR, 16'hff00}};
    cyc(20);
    sys_rst_i = 1'h0;
    cyc(1);
    chk({clear_out_buf_o, clear_in_proc_o}, 16'h0003);
    foreach (rows[i]) begin
      wr(rows[i].k, rows[i].d);
      q(rows[i].sel, rows[i].exp);
    end
    pulse(cmd_status_preset_i);
    cyc(1);
    q(QSEL_OEN, 16'h0000);
    q(QSEL_QNTR, 16'h0000);
    q(QSEL_OPTR, 16'hffff);
    q(QSEL_SRE, 16'h00a5);
    wr(1, 16'h0020);
    wr(2, 16'h0001);
    ops_idle_i = 1'h0;
    pulse(cmd_opc_i);
    cyc(4);
    chk(srq_o, 1'h0);
    ops_idle_i = 1'h1;
    wait_srq(1'h1);
    chk(status_byte_o, 8'h60);
    cyc(3);
    chk({srq_o, poll_byte}, 16'h0160);
    q(QSEL_STB, 16'h0060);
    pulse(cmd_cls_i);
    chk({srq_o, status_byte_o}, 16'h0000);
    q(QSEL_ESE, 16'h0001);
    wr(1, 16'h0004);
    event_err_i = 4'h8;
    for (int i = 0; i < 9; i++) begin
      err_code_i = 16'h0100 + 16'(i);
      cyc(1);
    end
    event_err_i = 4'h0;
    chk(status_byte_o, 8'h44);
    for (int i = 0; i < 9; i++) begin
      pulse(err_query_i);
      chk(err_code_o, (i < 8) ? 16'h0100 + 16'(i) : NO_ERROR_CODE);
      cyc(1);
    end
    chk(srq_o, 1'h0);
    q(QSEL_ESR, 16'h0020);
    event_err_i = 4'h1;
    cyc(1);
    event_err_i = 4'h0;
    pulse(cmd_cls_i);
    pulse(err_query_i);
    chk(err_code_o, 16'h0000);
    wr(1, 16'h0080);
    wr(4, 16'h0010);
    wr(5, 16'h0000);
    wr(6, 16'h0010);
    oper_cond_i = 16'h0010;
    cyc(4);
    chk(srq_o, 1'h0);
    oper_cond_i = 16'h0000;
    wait_srq(1'h1);
    chk(status_byte_o, 8'hc0);
    q(QSEL_OEVT, 16'h0010);
    chk(srq_o, 1'h0);
    wr(7, 16'h0001);
    ques_cond_i = 16'h0001;
    cyc(1);
    chk(status_byte_o, 8'h08);
    q(QSEL_QEVT, 16'h0001);
    wr(3, 16'h0010);
    mav_i = 1'h1;
    pp_line_i = 3'h3;
    pulse(pp_config_i);
    pp_active_i = 1'h1;
    cyc(1);
    chk({pp_data_oe_o, dio}, 16'h08ff);
    q(QSEL_IST, 16'h0001);
    pp_sense_i = 1'h1;
    pulse(pp_config_i);
    chk({pp_data_oe_o, dio}, 16'h08f7);
    mav_i = 1'h0;
    cyc(1);
    chk(ist_o, 1'h0);
    chk({pp_data_oe_o, dio}, 16'h08ff);
    pulse(pp_unconfig_i);
    chk(pp_data_oe_o, 8'h00);
    pp_active_i = 1'h0;
    pulse(cmd_dev_clear_i);
    chk({settings_reset_o, clear_out_buf_o, clear_in_proc_o}, 16'h0003);
    pulse(cmd_line_start_i);
    chk({settings_reset_o, clear_out_buf_o, clear_in_proc_o}, 16'h0002);
    pulse(cmd_settings_reset_i);
    chk({settings_reset_o, clear_out_buf_o, clear_in_proc_o}, 16'h0004);
    cyc(1);
    q(QSEL_SRE, 16'h0080);
    clk_en_i = 1'h0;
    pulse(cmd_line_start_i);
    chk(clear_out_buf_o, 1'h0);
    clk_en_i = 1'h1;
    pon_clear_flag_i = 1'h0;
    sys_rst_i = 1'h1;
    cyc(2);
    sys_rst_i = 1'h0;
    cyc(1);
    chk({clear_out_buf_o, clear_in_proc_o}, 16'h0003);
    cyc(1);
    q(QSEL_OPTR, 16'h0000);
    q(QSEL_ESR, 16'h0080);
    end_sim;
  end

  // The full sequence needs well under a thousand cycles; five thousand leaves ample margin.
  initial begin
    #200000;
    n_errors++;
    end_sim;
  end
endmodule : test_status_service_request_logic
`default_nettype wire
